// ### inc/trig_led_map.svh
// Register offsets, field positions, reset values and timing counts for the trigger/light block.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
`ifndef TRIG_LED_MAP_SVH
`define TRIG_LED_MAP_SVH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_PAT_CFG 8'h08
`define OFS_SRC_EN 8'h0C
`define OFS_PWM_RED 8'h10
`define OFS_PWM_GRN 8'h14
`define OFS_PWM_BLU 8'h18
`define OFS_GPIO_MODE 8'h1C
`define OFS_GPIO_OUT 8'h20
`define OFS_GPIO_IN 8'h24
`define OFS_GPIO_ALT 8'h28
`define OFS_PWM_ALT 8'h2C
`define CTRL_VIDEO_PAT 0
`define CTRL_SW_START 1
`define CTRL_SW_STOP 2
`define CTRL_SECONDARY 3
`define CTRL_SW_ADVANCE 4
`define STAT_RUNNING 0
`define STAT_EXPOSE 1
`define STAT_FIRST 2
`define PAT_CNT_RESET 8'h01
`define EXPOSE_CYC_RESET 16'h0064
`define GPIO_N 8
`define PWM_ALT_N 4
`define GPIO_MODE_RESET 16'h0000
`define UNMAPPED_READ 32'h0000_0000
`endif

// ### inc/trig_led_pkg.sv
// Types shared by the trigger/light block, its checker, its far-side model and its bench.
// Assumes trig_led_map.svh supplies the numeric constants.
package trig_led_pkg;
   typedef enum logic [1:0] {GPIO_IN, GPIO_OUT, GPIO_BIDIR, GPIO_OD} gpio_mode_t;
   typedef struct packed {
      logic [7:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
      logic cyc;
      logic stb;
   } wb_req_t;
   typedef struct packed {
      logic [31:0] dat;
      logic ack;
   } wb_rsp_t;
   typedef struct packed {
      logic [7:0] gpio_o;
      logic [7:0] gpio_oe_n;
   } gpio_drive_t;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_EXPOSE, SEQ_GAP} seq_state_t;
endpackage

// ### src/pwm_gen.sv
// Free-running 8-bit PWM generator; duty 0 gives constant low, 8'hFF near full.
// Assumes the caller registers nothing further; output is a flip-flop.
`timescale 1ns/1ps
module pwm_gen (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] duty_i,
   output logic pwm_o
);
   logic [7:0] cnt_q, cnt_d;
   logic pwm_q, pwm_d;
   ////////////////////////////////////////////////////////////////////////////////
   // Counter and compare
   always_comb begin
      cnt_d = cnt_q + 8'h01;
      pwm_d = (cnt_q < duty_i);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 8'h00;
         pwm_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         pwm_q <= pwm_d;
      end
   end
   assign pwm_o = pwm_q;
endmodule // pwm_gen

// ### src/trig_led_ctrl.sv
// Trigger and light-source control with general-purpose pins, Wishbone register slave.
// Assumes a single 25 MHz clock, synchronous reset, and asynchronous trigger pins.
//
// Summary of operation
// - in video pattern mode each advance trigger pulse after an exposure has ended steps to next pattern.
// - in video pattern mode a rising run trigger edge starts pattern display.
// - in video pattern mode a falling run trigger edge stops pattern display.
// - software start and stop commands also govern display, alongside the run trigger.
// - exposure output is high throughout each pattern exposure, low otherwise.
// - first-pattern output is high while the first pattern is displayed.
// - each colour has its own PWM current control output.
// - each colour has its own source enable output.
// - each general pin is input, output, bidirectional or open-drain by software.
// - some general pins can carry a PWM output instead of plain use.
// - all general pins come out of reset as inputs.
// - trigger and light functions act only on the primary controller.
`timescale 1ns/1ps
`include "trig_led_map.svh"
module trig_led_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire trig_led_pkg::wb_req_t wb_req_i,
   output trig_led_pkg::wb_rsp_t wb_rsp_o,
   input wire logic pattern_advance_in_i,
   input wire logic pattern_run_in_i,
   output logic exposure_active_out_o,
   output logic first_pattern_out_o,
   output logic red_current_pwm_o,
   output logic green_current_pwm_o,
   output logic blue_current_pwm_o,
   output logic red_source_on_o,
   output logic green_source_on_o,
   output logic blue_source_on_o,
   input wire logic [7:0] gpio_i,
   output trig_led_pkg::gpio_drive_t gpio_drv_o
);
   import trig_led_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   // Trigger synchronisers: three stages, change accepted when stages two and three agree
   logic [2:0] adv_sync_q, run_sync_q;
   logic [7:0] gpio_s1_q, gpio_s2_q, gpio_s3_q;
   logic adv_lvl_q, run_lvl_q;
   logic [7:0] gpio_lvl_q, gpio_lvl_d;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         adv_sync_q <= 3'h0;
         run_sync_q <= 3'h0;
         gpio_s1_q <= 8'h00;
         gpio_s2_q <= 8'h00;
         gpio_s3_q <= 8'h00;
      end else begin
         adv_sync_q <= {adv_sync_q[1:0], pattern_advance_in_i};
         run_sync_q <= {run_sync_q[1:0], pattern_run_in_i};
         gpio_s1_q <= gpio_i;
         gpio_s2_q <= gpio_s1_q;
         gpio_s3_q <= gpio_s2_q;
      end
   end
   // Filtered levels; stage 0 feeds only stage 1
   logic adv_lvl_d, run_lvl_d;
   always_comb begin
      adv_lvl_d = (adv_sync_q[1] == adv_sync_q[2]) ? adv_sync_q[2] : adv_lvl_q;
      run_lvl_d = (run_sync_q[1] == run_sync_q[2]) ? run_sync_q[2] : run_lvl_q;
      gpio_lvl_d = (gpio_s3_q & ~(gpio_s2_q ^ gpio_s3_q)) | (gpio_lvl_q & (gpio_s2_q ^ gpio_s3_q)); // Keep old on disagreement
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         adv_lvl_q <= 1'b0;
         run_lvl_q <= 1'b0;
         gpio_lvl_q <= 8'h00;
      end else begin
         adv_lvl_q <= adv_lvl_d;
         run_lvl_q <= run_lvl_d;
         gpio_lvl_q <= gpio_lvl_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Software registers
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] pat_cnt_q, pat_cnt_d;
   logic [15:0] expose_cyc_q, expose_cyc_d;
   logic [2:0] src_en_q, src_en_d;
   logic [7:0] duty_r_q, duty_r_d, duty_g_q, duty_g_d, duty_b_q, duty_b_d;
   logic [15:0] gpio_mode_q, gpio_mode_d;
   logic [7:0] gpio_out_q, gpio_out_d;
   logic [3:0] gpio_alt_q, gpio_alt_d;
   logic [7:0] duty_alt_q [0:3];
   logic [7:0] duty_alt_d [0:3];
   wb_rsp_t rsp_q, rsp_d;
   logic sw_start, sw_stop, sw_adv;
   logic running_q, expose_q, first_q;

   // Byte-lane merge used by every write except OFS_PWM_ALT, which copies its selected bytes directly
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction
   logic wr_en, rd_en;
   logic [31:0] rd_val;
   assign wr_en = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~rsp_q.ack;
   assign rd_en = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~rsp_q.ack;
   // Register writes; command bits are pulses that never store
   always_comb begin
      ctrl_d = ctrl_q;
      pat_cnt_d = pat_cnt_q;
      expose_cyc_d = expose_cyc_q;
      src_en_d = src_en_q;
      duty_r_d = duty_r_q;
      duty_g_d = duty_g_q;
      duty_b_d = duty_b_q;
      gpio_mode_d = gpio_mode_q;
      gpio_out_d = gpio_out_q;
      gpio_alt_d = gpio_alt_q;
      duty_alt_d = duty_alt_q;
      sw_start = 1'b0;
      sw_stop = 1'b0;
      sw_adv = 1'b0;
      if (wr_en) begin
         unique case (wb_req_i.adr)
            `OFS_CTRL: begin
               ctrl_d = 8'(lane_merge({24'h0, ctrl_q}, wb_req_i.dat, wb_req_i.sel));
               ctrl_d[`CTRL_SW_START] = 1'b0;
               ctrl_d[`CTRL_SW_STOP] = 1'b0;
               ctrl_d[`CTRL_SW_ADVANCE] = 1'b0;
               sw_start = wb_req_i.sel[0] & wb_req_i.dat[`CTRL_SW_START];
               sw_stop = wb_req_i.sel[0] & wb_req_i.dat[`CTRL_SW_STOP];
               sw_adv = wb_req_i.sel[0] & wb_req_i.dat[`CTRL_SW_ADVANCE];
            end
            `OFS_PAT_CFG: begin
               pat_cnt_d = 8'(lane_merge({8'h0, expose_cyc_q, pat_cnt_q}, wb_req_i.dat, wb_req_i.sel));
               expose_cyc_d = 16'(lane_merge({8'h0, expose_cyc_q, pat_cnt_q}, wb_req_i.dat, wb_req_i.sel) >> 8);
            end
            `OFS_SRC_EN: src_en_d = 3'(lane_merge({29'h0, src_en_q}, wb_req_i.dat, wb_req_i.sel));
            `OFS_PWM_RED: duty_r_d = 8'(lane_merge({24'h0, duty_r_q}, wb_req_i.dat, wb_req_i.sel));
            `OFS_PWM_GRN: duty_g_d = 8'(lane_merge({24'h0, duty_g_q}, wb_req_i.dat, wb_req_i.sel));
            `OFS_PWM_BLU: duty_b_d = 8'(lane_merge({24'h0, duty_b_q}, wb_req_i.dat, wb_req_i.sel));
            `OFS_GPIO_MODE: gpio_mode_d = 16'(lane_merge({16'h0, gpio_mode_q}, wb_req_i.dat, wb_req_i.sel));
            `OFS_GPIO_OUT: gpio_out_d = 8'(lane_merge({24'h0, gpio_out_q}, wb_req_i.dat, wb_req_i.sel));
            `OFS_GPIO_ALT: gpio_alt_d = 4'(lane_merge({28'h0, gpio_alt_q}, wb_req_i.dat, wb_req_i.sel));
            `OFS_PWM_ALT: begin
               for (int i = 0; i < `PWM_ALT_N; i++) begin
                  if (wb_req_i.sel[i]) begin
                     duty_alt_d[i] = wb_req_i.dat[i*8 +: 8];
                  end
               end
            end
            default: ;
         endcase
      end
   end
   // Read mux and one-cycle ack
   always_comb begin
      rd_val = `UNMAPPED_READ;
      unique case (wb_req_i.adr)
         `OFS_CTRL: rd_val = {24'h0, ctrl_q};
         `OFS_STATUS: rd_val = {29'h0, first_q, expose_q, running_q};
         `OFS_PAT_CFG: rd_val = {8'h0, expose_cyc_q, pat_cnt_q};
         `OFS_SRC_EN: rd_val = {29'h0, src_en_q};
         `OFS_PWM_RED: rd_val = {24'h0, duty_r_q};
         `OFS_PWM_GRN: rd_val = {24'h0, duty_g_q};
         `OFS_PWM_BLU: rd_val = {24'h0, duty_b_q};
         `OFS_GPIO_MODE: rd_val = {16'h0, gpio_mode_q};
         `OFS_GPIO_OUT: rd_val = {24'h0, gpio_out_q};
         `OFS_GPIO_IN: rd_val = {24'h0, gpio_lvl_q};
         `OFS_GPIO_ALT: rd_val = {28'h0, gpio_alt_q};
         `OFS_PWM_ALT: rd_val = {duty_alt_q[3], duty_alt_q[2], duty_alt_q[1], duty_alt_q[0]};
         default: ;
      endcase
      rsp_d.ack = wr_en | rd_en;
      rsp_d.dat = rd_en ? rd_val : 32'h0000_0000;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= 8'h00;
         pat_cnt_q <= `PAT_CNT_RESET;
         expose_cyc_q <= `EXPOSE_CYC_RESET;
         src_en_q <= 3'h0;
         duty_r_q <= 8'h00;
         duty_g_q <= 8'h00;
         duty_b_q <= 8'h00;
         gpio_mode_q <= `GPIO_MODE_RESET;
         gpio_out_q <= 8'h00;
         gpio_alt_q <= 4'h0;
         for (int i = 0; i < `PWM_ALT_N; i++) begin
            duty_alt_q[i] <= 8'h00;
         end
         rsp_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         pat_cnt_q <= pat_cnt_d;
         expose_cyc_q <= expose_cyc_d;
         src_en_q <= src_en_d;
         duty_r_q <= duty_r_d;
         duty_g_q <= duty_g_d;
         duty_b_q <= duty_b_d;
         gpio_mode_q <= gpio_mode_d;
         gpio_out_q <= gpio_out_d;
         gpio_alt_q <= gpio_alt_d;
         duty_alt_q <= duty_alt_d;
         rsp_q <= rsp_d;
      end
   end
   assign wb_rsp_o = rsp_q;
   ////////////////////////////////////////////////////////////////////////////////
   // Pattern sequencer
   logic primary, video_mode, adv_pulse, run_rise, run_fall;
   seq_state_t st_q, st_d;
   logic running_d, expose_d, first_d;
   logic [7:0] idx_q, idx_d;
   logic [15:0] tmr_q, tmr_d;
   assign primary = ~ctrl_q[`CTRL_SECONDARY];
   assign video_mode = ctrl_q[`CTRL_VIDEO_PAT] & primary;
   assign adv_pulse = video_mode & ((adv_lvl_d & ~adv_lvl_q) | sw_adv);
   assign run_rise = run_lvl_d & ~run_lvl_q;
   assign run_fall = ~run_lvl_d & run_lvl_q;
   // Run state, pattern index and exposure timer
   always_comb begin
      st_d = st_q;
      running_d = running_q;
      idx_d = idx_q;
      tmr_d = tmr_q;
      // Stop wins over start when both arrive together, so a halt is never lost
      if (!video_mode || (run_fall | sw_stop)) begin
         running_d = 1'b0;
      end else if (run_rise | sw_start) begin
         running_d = 1'b1;
         if (!running_q) begin
            idx_d = 8'h00;
            st_d = SEQ_EXPOSE;
            tmr_d = expose_cyc_q;
         end
      end
      if (!running_d) begin
         st_d = SEQ_IDLE;
      end else if (running_q) begin
         unique case (st_q)
            SEQ_EXPOSE: begin
               if (tmr_q > 16'h0001) begin
                  tmr_d = tmr_q - 16'h0001;
               end else begin
                  st_d = SEQ_GAP; // Hold until an advance pulse arrives
               end
            end
            SEQ_GAP, SEQ_IDLE: begin
               if (adv_pulse) begin
                  idx_d = (idx_q + 8'h01 >= pat_cnt_q) ? 8'h00 : idx_q + 8'h01;
                  st_d = SEQ_EXPOSE;
                  tmr_d = expose_cyc_q;
               end
            end
         endcase
      end
      expose_d = (st_d == SEQ_EXPOSE);
      first_d = running_d & (idx_d == 8'h00);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= SEQ_IDLE;
         running_q <= 1'b0;
         expose_q <= 1'b0;
         first_q <= 1'b0;
         idx_q <= 8'h00;
         tmr_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         running_q <= running_d;
         expose_q <= expose_d;
         first_q <= first_d;
         idx_q <= idx_d;
         tmr_q <= tmr_d;
      end
   end
   assign exposure_active_out_o = expose_q;
   assign first_pattern_out_o = first_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Light sources: enables registered, PWM from leaf generators
   logic [2:0] src_on_q;
   logic [6:0] pwm_raw;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_on_q <= 3'h0;
      end else begin
         src_on_q <= src_en_q & {3{primary}};
      end
   end
   assign red_source_on_o = src_on_q[0];
   assign green_source_on_o = src_on_q[1];
   assign blue_source_on_o = src_on_q[2];
   // Each colour keeps its own generator so duties never interact
   pwm_gen u_pwm_r (.clk_i(clk_i), .rst_i(rst_i), .duty_i(primary ? duty_r_q : 8'h00), .pwm_o(pwm_raw[0]));
   pwm_gen u_pwm_g (.clk_i(clk_i), .rst_i(rst_i), .duty_i(primary ? duty_g_q : 8'h00), .pwm_o(pwm_raw[1]));
   pwm_gen u_pwm_b (.clk_i(clk_i), .rst_i(rst_i), .duty_i(primary ? duty_b_q : 8'h00), .pwm_o(pwm_raw[2]));
   pwm_gen u_pwm_a0 (.clk_i(clk_i), .rst_i(rst_i), .duty_i(duty_alt_q[0]), .pwm_o(pwm_raw[3]));
   pwm_gen u_pwm_a1 (.clk_i(clk_i), .rst_i(rst_i), .duty_i(duty_alt_q[1]), .pwm_o(pwm_raw[4]));
   pwm_gen u_pwm_a2 (.clk_i(clk_i), .rst_i(rst_i), .duty_i(duty_alt_q[2]), .pwm_o(pwm_raw[5]));
   pwm_gen u_pwm_a3 (.clk_i(clk_i), .rst_i(rst_i), .duty_i(duty_alt_q[3]), .pwm_o(pwm_raw[6]));
   assign red_current_pwm_o = pwm_raw[0];
   assign green_current_pwm_o = pwm_raw[1];
   assign blue_current_pwm_o = pwm_raw[2];
   ////////////////////////////////////////////////////////////////////////////////
   // General pins: enable low drives; open-drain only ever drives low
   gpio_drive_t gpio_q, gpio_d;
   always_comb begin
      for (int i = 0; i < `GPIO_N; i++) begin
         logic val;
         val = (i < `PWM_ALT_N && gpio_alt_q[i % 4]) ? pwm_raw[3 + (i % 4)] : gpio_out_q[i];
         gpio_d.gpio_o[i] = val;
         unique case (gpio_mode_t'(gpio_mode_q[i*2 +: 2]))
            GPIO_IN: gpio_d.gpio_oe_n[i] = 1'b1;
            GPIO_OUT, GPIO_BIDIR: gpio_d.gpio_oe_n[i] = 1'b0;
            GPIO_OD: begin
               gpio_d.gpio_o[i] = 1'b0;
               gpio_d.gpio_oe_n[i] = val;
            end
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gpio_q.gpio_o <= 8'h00;
         gpio_q.gpio_oe_n <= 8'hFF;
      end else begin
         gpio_q <= gpio_d;
      end
   end
   assign gpio_drv_o = gpio_q;
endmodule // trig_led_ctrl

// ### verif/trig_led_checker.sv
// Concurrent checks on the trigger/light block ports: bus handshake, reset state, trigger timing.
// Assumes it is bound to trig_led_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module trig_led_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire trig_led_pkg::wb_req_t wb_req_i,
   input wire trig_led_pkg::wb_rsp_t wb_rsp_o,
   input wire logic pattern_advance_in_i,
   input wire logic pattern_run_in_i,
   input wire logic exposure_active_out_o,
   input wire logic first_pattern_out_o,
   input wire trig_led_pkg::gpio_drive_t gpio_drv_o
);
   import trig_led_pkg::*;
   ////////////////////////////////////////////////////////////
   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Bus answers one cycle after a fresh request, for one cycle only
   a_ack_next_cycle: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
      else $error("ack did not follow request");
   a_ack_one_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
      else $error("ack held longer than one cycle");
   a_ack_has_cause: assert property ($rose(wb_rsp_o.ack) |-> $past(wb_req_i.cyc && wb_req_i.stb))
      else $error("ack without request");
   a_unmapped_reads_zero: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && !wb_req_i.we
      && wb_req_i.adr > 8'h2C |=> wb_rsp_o.dat == 32'h0000_0000)
      else $error("unmapped read not zero");
   // Reset state is seen at the first edge after release
   a_gpio_reset_input: assert property ($fell(rst_i) |-> gpio_drv_o.gpio_oe_n == 8'hFF)
      else $error("pins not released after reset");
   a_trig_out_quiet: assert property ($fell(rst_i) |-> !exposure_active_out_o && !first_pattern_out_o)
      else $error("trigger outputs active after reset");
   a_first_with_exposure: assert property ($rose(first_pattern_out_o) |-> exposure_active_out_o)
      else $error("first pattern flag rose outside exposure");
   // A synchroniser of two or more stages cannot react in one cycle
   a_run_sync_delay: assert property ($rose(pattern_run_in_i) |=> !$rose(exposure_active_out_o))
      else $error("run trigger seen too early");
   a_adv_sync_delay: assert property ($rose(pattern_advance_in_i) |=> !$rose(exposure_active_out_o))
      else $error("advance trigger seen too early");
endmodule // trig_led_checker
bind trig_led_ctrl trig_led_checker trig_led_checker_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
   .wb_rsp_o(wb_rsp_o), .pattern_advance_in_i(pattern_advance_in_i), .pattern_run_in_i(pattern_run_in_i),
   .exposure_active_out_o(exposure_active_out_o), .first_pattern_out_o(first_pattern_out_o),
   .gpio_drv_o(gpio_drv_o));

// ### verif/trig_far_side.sv
// Far side of the block: camera/sensor trigger source and the board wiring of the general pins.
// Assumes triggers are asynchronous to the block clock; every pin has an external pull-up.
`timescale 1ns/1ps
module trig_far_side (
   input wire trig_led_pkg::gpio_drive_t gpio_drv_i,
   input wire logic [7:0] ext_val_i,
   input wire logic [7:0] ext_en_i,
   output logic [7:0] gpio_o,
   output logic pattern_advance_o,
   output logic pattern_run_o
);
   import trig_led_pkg::*;
   initial begin
      pattern_advance_o = 1'b0;
      pattern_run_o = 1'b0;
   end
   // Wire level: block drive wins, then external driver, else the pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         gpio_o[i] = !gpio_drv_i.gpio_oe_n[i] ? gpio_drv_i.gpio_o[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b1);
      end
   end
   // Odd delays keep edges off the clock grid, as a real camera would
   task automatic pulse_advance(input int width_ns);
      #7 pattern_advance_o = 1'b1;
      #(width_ns) pattern_advance_o = 1'b0;
   endtask
   task automatic set_run(input logic v);
      #11 pattern_run_o = v;
   endtask
endmodule // trig_far_side

// ### verif/trig_led_ctrl_tb_top.sv
// Self-checking bench for the trigger/light block: registers, pins, PWM and the pattern sequencer.
// Assumes the far-side model drives triggers and resolves the general pins with pull-ups.
`timescale 1ns/1ps
`include "trig_led_map.svh"
module trig_led_ctrl_tb_top;
   import trig_led_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   wb_req_t wb_req = '0;
   wb_rsp_t wb_rsp;
   logic adv, run, expo, first, seen;
   logic [2:0] pwm, src;
   logic [7:0] gpio_in, ext_val = 8'h00, ext_en = 8'h00, v;
   logic [31:0] q;
   gpio_drive_t drv;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   int hi[5];
   int len;
   logic [7:0] duty[3];
   trig_led_ctrl trig_led_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
      .pattern_advance_in_i(adv), .pattern_run_in_i(run), .exposure_active_out_o(expo),
      .first_pattern_out_o(first), .red_current_pwm_o(pwm[0]), .green_current_pwm_o(pwm[1]),
      .blue_current_pwm_o(pwm[2]), .red_source_on_o(src[0]), .green_source_on_o(src[1]),
      .blue_source_on_o(src[2]), .gpio_i(gpio_in), .gpio_drv_o(drv));
   trig_far_side trig_far_side_i (.gpio_drv_i(drv), .ext_val_i(ext_val), .ext_en_i(ext_en), .gpio_o(gpio_in),
      .pattern_advance_o(adv), .pattern_run_o(run));
   ////////////////////////////////////////////////////////////
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // Hang guard: the whole run needs well under this many cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         miscompares++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_cnt(input string nm, input int e, input int g);
      tests_run++;
      if (g != e) begin
         miscompares++;
         $display("wrong value %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   // Classic cycle: hold everything until ack is sampled, take data at that edge, then release
   task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_req <= '{adr: a, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_rsp.ack !== 1'b1 && n < 100);
      r = wb_rsp.dat;
      wb_req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb_cycle(a, 1'b1, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      wb_cycle(a, 1'b0, 32'h0000_0000, r);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // Exposure length counted in clocks, first-pattern flag taken at its start
   task automatic expose_len(output int l, output logic f);
      int n;
      l = 0;
      n = 0;
      f = 1'bx;
      while (expo !== 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      f = first;
      while (expo === 1'b1 && l < 1000) begin
         @(negedge clk_i);
         l++;
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h3139));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values, refused writes and an unmapped place
      rd(`OFS_PAT_CFG, q);
      chk_val("pattern config", 32'h0000_6401, q);
      rd(`OFS_GPIO_MODE, q);
      chk_val("pin mode", 32'h0000_0000, q);
      chk_val("pin enables", 32'h0000_00FF, drv.gpio_oe_n);
      wr(8'h30, 32'hFFFF_FFFF);
      rd(8'h30, q);
      chk_val("unmapped read", 32'h0000_0000, q);
      wr(`OFS_STATUS, 32'hFFFF_FFFF);
      rd(`OFS_STATUS, q);
      chk_val("status", 32'h0000_0000, q);
      $display("test reset done");
      // Input, output, bidirectional and open-drain pin modes
      v = $urandom;
      @(posedge clk_i);
      ext_val <= v;
      ext_en <= 8'hFF;
      idle(6);
      rd(`OFS_GPIO_IN, q);
      chk_val("pin input", {24'h0, v}, q);
      @(posedge clk_i);
      ext_en <= 8'h00;
      for (int m = 1; m < 4; m++) begin
         v = $urandom;
         wr(`OFS_GPIO_OUT, {24'h0, v});
         wr(`OFS_GPIO_MODE, {16'h0, {8{m[1:0]}}});
         idle(6);
         chk_val("pin value", (m == 3) ? 32'h0 : {24'h0, v}, drv.gpio_o);
         chk_val("pin enables", (m == 3) ? {24'h0, v} : 32'h0, drv.gpio_oe_n);
         rd(`OFS_GPIO_IN, q);
         chk_val("pin readback", {24'h0, v}, q);
      end
      $display("test pin modes done");
      // Alternate PWM on pins 0 and 1 beside colour duties of zero, full and random
      wr(`OFS_GPIO_MODE, 32'h0000_5555);
      wr(`OFS_GPIO_OUT, 32'h0000_00FF);
      wr(`OFS_PWM_ALT, 32'h0000_FF00);
      wr(`OFS_GPIO_ALT, 32'h0000_0003);
      for (int c = 0; c < 3; c++) begin
         duty[c] = (c == 0) ? 8'h00 : ((c == 1) ? 8'hFF : 8'($urandom));
         wr(8'h10 + 8'(4 * c), {24'h0, duty[c]});
      end
      idle(300);
      hi = '{default: 0};
      repeat (256) begin
         @(negedge clk_i);
         for (int k = 0; k < 3; k++) hi[k] += (pwm[k] === 1'b1);
         hi[3] += (drv.gpio_o[0] === 1'b1);
         hi[4] += (drv.gpio_o[1] === 1'b1);
      end
      for (int c = 0; c < 3; c++) chk_cnt("colour pwm", duty[c], hi[c]);
      chk_cnt("alt pwm 0", 0, hi[3]);
      chk_cnt("alt pwm 1", 255, hi[4]);
      $display("test pwm done");
      // Source enables
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 8'h07 : 8'($urandom);
         wr(`OFS_SRC_EN, {29'h0, v[2:0]});
         idle(2);
         chk_val("source enables", {29'h0, v[2:0]}, src);
      end
      $display("test sources done");
      // Run trigger starts, trigger or software advance steps and wraps, run falling stops
      wr(`OFS_CTRL, 32'h0000_0001);
      wr(`OFS_PAT_CFG, 32'h0000_1403);
      trig_far_side_i.set_run(1'b1);
      expose_len(len, seen);
      chk_cnt("exposure length", 20, len);
      chk_val("first pattern", 32'h1, seen);
      for (int i = 1; i <= 3; i++) begin
         if (i == 2) begin
            wr(`OFS_CTRL, 32'h0000_0011);
         end else begin
            trig_far_side_i.pulse_advance(60 + 20 * i);
         end
         expose_len(len, seen);
         chk_cnt("exposure length", 20, len);
         chk_val("first pattern", (i == 3) ? 32'h1 : 32'h0, seen);
      end
      trig_far_side_i.set_run(1'b0);
      idle(10);
      rd(`OFS_STATUS, q);
      chk_val("running", 32'h0, q[0]);
      // Software start and stop share control with the trigger
      wr(`OFS_CTRL, 32'h0000_0003);
      rd(`OFS_STATUS, q);
      chk_val("running", 32'h1, q[0]);
      wr(`OFS_CTRL, 32'h0000_0005);
      idle(4);
      rd(`OFS_STATUS, q);
      chk_val("running", 32'h0, q[0]);
      $display("test sequencer done");
      // Secondary role silences triggers and sources
      wr(`OFS_CTRL, 32'h0000_0009);
      trig_far_side_i.set_run(1'b1);
      seen = 1'b0;
      repeat (40) begin
         @(negedge clk_i);
         seen = seen | (expo !== 1'b0);
      end
      chk_val("secondary exposure", 32'h0, seen);
      chk_val("secondary sources", 32'h0, src);
      chk_val("secondary pwm", 32'h0, pwm);
      $display("test secondary done");
      test_done();
   end
endmodule // trig_led_ctrl_tb_top
